// ==== rtl/pmh_pkg.sv ====
// Package for the power-mode and hibernate sequencer
package pmh_pkg;

	// ----------------------------------------
	// Operating modes
	// ----------------------------------------
	typedef enum logic [2:0] {
		PMH_FULL_ON,
		PMH_ACTIVE,
		PMH_SLEEP,
		PMH_DEEP_SLEEP,
		PMH_HIBERNATE,
		PMH_BOOT
	} pmh_mode_t;

	// ----------------------------------------
	// Regulator control layout
	// ----------------------------------------
	localparam int PMH_REGULATOR_FIELD_A_LSB = 0;
	localparam int PMH_REGULATOR_FIELD_A_W = 2;
	localparam int PMH_GAIN_LSB = 2;
	localparam int PMH_GAIN_W = 2;
	localparam int PMH_LEVEL_LSB = 4;
	localparam int PMH_LEVEL_W = 4;
	localparam int PMH_WAKE_EN_LSB = 8;
	localparam int PMH_WAKE_EN_W = 5;
	localparam int PMH_CTL_W = 16;
	localparam logic [PMH_REGULATOR_FIELD_A_W-1:0] PMH_REGULATOR_FIELD_A_OFF = 2'h0;
	localparam logic [PMH_CTL_W-1:0] PMH_CTL_RESET = 16'h1FB3;

	// Core voltage: base plus level times step, in millivolts
	localparam int PMH_VOLT_STEP_MV = 50;
	localparam int PMH_VOLT_BASE_MV = 850;
	localparam int PMH_MV_W = 11;

	// Wake source bit positions inside the enable field
	localparam int PMH_WK_RTC = 0;
	localparam int PMH_WK_CAN = 1;
	localparam int PMH_WK_RESET = 2;
	localparam int PMH_WK_RING = 3;
	localparam int PMH_WK_GP = 4;

	// Boot sequence length in cycles
	localparam int PMH_BOOT_TIME_NS = 1000;
	localparam int PMH_CLK_NS = 10;
	localparam int PMH_BOOT_CYCLES = (PMH_BOOT_TIME_NS + PMH_CLK_NS - 1) / PMH_CLK_NS;
	localparam int PMH_BOOT_CNT_W = 8;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic rtc;
		logic can;
		logic reset;
		logic ring_rx_activity_pin;
		logic gp;
	} pmh_wake_t;

	typedef struct packed {
		logic core_clk_en;
		logic sys_clk_en;
		logic pll_en;
		logic pll_bypass;
		logic async_block;
		logic pins_hiz;
		logic supply_on;
	} pmh_ctrl_t;

endpackage

// ==== rtl/pmh_wake_combine.sv ====
// Hibernate wake source combiner
`timescale 1ns/1ps
`default_nettype none
module pmh_wake_combine (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire pmh_pkg::pmh_wake_t i_src,
	input wire logic [pmh_pkg::PMH_WAKE_EN_W-1:0] i_en,
	input wire logic i_ring_used,
	input wire logic i_can_used,
	output logic o_wake
);
	logic [pmh_pkg::PMH_WAKE_EN_W-1:0] src;
	logic [pmh_pkg::PMH_WAKE_EN_W-1:0] gate;
	logic next_wake;

	// ----------------------------------------
	// OR of enabled sources
	// ----------------------------------------
	always_comb begin
		src = {i_src.gp, i_src.ring_rx_activity_pin, i_src.reset, i_src.can, i_src.rtc};
		gate = i_en;
		gate[pmh_pkg::PMH_WK_RESET] = 1'b1;
		gate[pmh_pkg::PMH_WK_GP] = i_en[pmh_pkg::PMH_WK_GP] & ~(i_ring_used & i_can_used);
		next_wake = |(src & gate);
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_wake <= 1'b0;
		end else begin
			o_wake <= next_wake;
		end
	end
endmodule
`default_nettype wire

// ==== rtl/pmh_seq.sv ====
// Power-mode and hibernate sequencer top
// ----------------------------------------
// Summary of operation
// - Deep sleep stops core and system clocks
// - Deep sleep blocks async peripheral bus access
// - Deep sleep exits only on reset or RTC
// - RTC wake from deep sleep enters active
// - Reset in deep sleep enters full-on
// - Frequency field zero in full-on or active, without external supply, enters hibernate, supply off
// - Hibernate puts external pins high impedance
// - RTC, CAN, reset, ring activity wake regulator
// - General wake offered when CAN or ring unused
// - Core voltage adjustable in 50 mV steps
// - Every hibernate wake runs full boot
// - Regulator may be disabled and bypassed
// - Full-on runs PLL, not bypassed
// - Active runs PLL bypassed
// ----------------------------------------
`timescale 1ns/1ps
`default_nettype none
module pmh_seq (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_reg_we,
	input wire logic [pmh_pkg::PMH_CTL_W-1:0] i_reg_wdata,
	input wire logic i_sleep_req,
	input wire logic i_deep_sleep_req,
	input wire logic i_active_req,
	input wire logic i_full_on_req,
	input wire logic i_pll_bypass_cfg,
	input wire logic i_wake_evt,
	input wire logic i_rtc_async_irq,
	input wire logic i_reset_pin,
	input wire pmh_pkg::pmh_wake_t i_wake_src,
	input wire logic i_ring_used,
	input wire logic i_can_used,
	input wire logic i_ext_supply,
	output logic [pmh_pkg::PMH_CTL_W-1:0] o_regulator_control_reg,
	output pmh_pkg::pmh_ctrl_t o_ctrl,
	output pmh_pkg::pmh_mode_t o_mode,
	output logic o_boot_start,
	output logic o_reg_enable,
	output logic o_reg_bypass,
	output logic [pmh_pkg::PMH_MV_W-1:0] o_core_mv
);
	pmh_pkg::pmh_mode_t mode;
	pmh_pkg::pmh_mode_t next_mode;
	logic [pmh_pkg::PMH_CTL_W-1:0] ctl;
	logic [pmh_pkg::PMH_CTL_W-1:0] next_ctl;
	logic [pmh_pkg::PMH_BOOT_CNT_W-1:0] boot_cnt;
	logic [pmh_pkg::PMH_BOOT_CNT_W-1:0] next_boot_cnt;
	pmh_pkg::pmh_ctrl_t next_ctrl;
	logic next_boot_start;
	logic [pmh_pkg::PMH_MV_W-1:0] next_mv;
	logic hib_wake;
	logic [pmh_pkg::PMH_REGULATOR_FIELD_A_W-1:0] regulator_field_a;
	logic [pmh_pkg::PMH_LEVEL_W-1:0] level;

	// ----------------------------------------
	// Wake combiner
	// ----------------------------------------
	pmh_wake_combine u_wake (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_src(i_wake_src),
		.i_en(ctl[pmh_pkg::PMH_WAKE_EN_LSB +: pmh_pkg::PMH_WAKE_EN_W]),
		.i_ring_used(i_ring_used),
		.i_can_used(i_can_used),
		.o_wake(hib_wake)
	);

	// ----------------------------------------
	// Mode sequencing
	// ----------------------------------------
	always_comb begin
		next_mode = mode;
		next_ctl = ctl;
		next_boot_cnt = boot_cnt;
		next_boot_start = 1'b0;
		regulator_field_a = i_reg_wdata[pmh_pkg::PMH_REGULATOR_FIELD_A_LSB +: pmh_pkg::PMH_REGULATOR_FIELD_A_W];
		if (i_reg_we && mode != pmh_pkg::PMH_HIBERNATE) begin
			next_ctl = i_reg_wdata;
		end
		unique case (mode)
			pmh_pkg::PMH_FULL_ON, pmh_pkg::PMH_ACTIVE: begin
				if (i_reg_we && regulator_field_a == pmh_pkg::PMH_REGULATOR_FIELD_A_OFF && !i_ext_supply) begin
					next_mode = pmh_pkg::PMH_HIBERNATE;
				end else if (i_deep_sleep_req) begin
					next_mode = pmh_pkg::PMH_DEEP_SLEEP;
				end else if (i_sleep_req) begin
					next_mode = pmh_pkg::PMH_SLEEP;
				end else if (mode == pmh_pkg::PMH_FULL_ON && i_active_req) begin
					next_mode = pmh_pkg::PMH_ACTIVE;
				end else if (mode == pmh_pkg::PMH_ACTIVE && i_full_on_req) begin
					next_mode = pmh_pkg::PMH_FULL_ON;
				end
			end
			pmh_pkg::PMH_SLEEP: begin
				if (i_reset_pin) begin
					next_mode = pmh_pkg::PMH_FULL_ON;
				end else if (i_wake_evt || i_rtc_async_irq) begin
					next_mode = i_pll_bypass_cfg ? pmh_pkg::PMH_ACTIVE : pmh_pkg::PMH_FULL_ON;
				end
			end
			pmh_pkg::PMH_DEEP_SLEEP: begin
				if (i_reset_pin) begin
					next_mode = pmh_pkg::PMH_FULL_ON;
				end else if (i_rtc_async_irq) begin
					next_mode = pmh_pkg::PMH_ACTIVE;
				end
			end
			pmh_pkg::PMH_HIBERNATE: begin
				if (hib_wake) begin
					next_mode = pmh_pkg::PMH_BOOT;
					next_ctl = pmh_pkg::PMH_CTL_RESET;
					next_boot_cnt = '0;
				end
			end
			pmh_pkg::PMH_BOOT: begin
				if (boot_cnt == 8'(pmh_pkg::PMH_BOOT_CYCLES - 1)) begin
					next_mode = pmh_pkg::PMH_FULL_ON;
					next_boot_start = 1'b1;
				end else begin
					next_boot_cnt = boot_cnt + 8'h01;
				end
			end
			default: begin
				next_mode = pmh_pkg::PMH_FULL_ON;
			end
		endcase
	end

	// ----------------------------------------
	// Clock, pin and supply controls
	// ----------------------------------------
	always_comb begin
		next_ctrl = '0;
		next_ctrl.supply_on = 1'b1;
		unique case (next_mode)
			pmh_pkg::PMH_FULL_ON: begin
				next_ctrl.core_clk_en = 1'b1;
				next_ctrl.sys_clk_en = 1'b1;
				next_ctrl.pll_en = 1'b1;
			end
			pmh_pkg::PMH_ACTIVE: begin
				next_ctrl.core_clk_en = 1'b1;
				next_ctrl.sys_clk_en = 1'b1;
				next_ctrl.pll_en = 1'b1;
				next_ctrl.pll_bypass = 1'b1;
			end
			pmh_pkg::PMH_SLEEP: begin
				next_ctrl.sys_clk_en = 1'b1;
				next_ctrl.pll_en = 1'b1;
			end
			pmh_pkg::PMH_DEEP_SLEEP: begin
				next_ctrl.async_block = 1'b1;
			end
			pmh_pkg::PMH_HIBERNATE: begin
				next_ctrl.async_block = 1'b1;
				next_ctrl.pins_hiz = 1'b1;
				next_ctrl.supply_on = 1'b0;
			end
			pmh_pkg::PMH_BOOT: begin
				next_ctrl.async_block = 1'b1;
			end
			default: begin
				next_ctrl = '0;
			end
		endcase
		level = next_ctl[pmh_pkg::PMH_LEVEL_LSB +: pmh_pkg::PMH_LEVEL_W];
		next_mv = 11'(pmh_pkg::PMH_VOLT_BASE_MV) + 11'(level) * 11'(pmh_pkg::PMH_VOLT_STEP_MV);
		if (!next_ctrl.supply_on) begin
			next_mv = '0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			mode <= pmh_pkg::PMH_FULL_ON;
			ctl <= pmh_pkg::PMH_CTL_RESET;
			boot_cnt <= '0;
			o_ctrl <= '{core_clk_en: 1'b1, sys_clk_en: 1'b1, pll_en: 1'b1, pll_bypass: 1'b0,
				async_block: 1'b0, pins_hiz: 1'b0, supply_on: 1'b1};
			o_mode <= pmh_pkg::PMH_FULL_ON;
			o_boot_start <= 1'b0;
			o_regulator_control_reg <= pmh_pkg::PMH_CTL_RESET;
			o_reg_enable <= 1'b1;
			o_reg_bypass <= 1'b0;
			o_core_mv <= 11'(pmh_pkg::PMH_VOLT_BASE_MV + pmh_pkg::PMH_VOLT_STEP_MV
				* int'(pmh_pkg::PMH_CTL_RESET[pmh_pkg::PMH_LEVEL_LSB +: pmh_pkg::PMH_LEVEL_W]));
		end else begin
			mode <= next_mode;
			ctl <= next_ctl;
			boot_cnt <= next_boot_cnt;
			o_ctrl <= next_ctrl;
			o_mode <= next_mode;
			o_boot_start <= next_boot_start;
			o_regulator_control_reg <= next_ctl;
			o_reg_enable <= next_ctrl.supply_on & ~i_ext_supply;
			o_reg_bypass <= i_ext_supply;
			o_core_mv <= next_mv;
		end
	end
endmodule
`default_nettype wire

// ==== bench/pmh_seq_properties.sv ====
// Concurrent checks on the power-mode sequencer ports
`timescale 1ns/1ps
`default_nettype none
module pmh_seq_properties (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_reg_we,
	input wire logic [15:0] i_reg_wdata,
	input wire logic i_rtc_async_irq,
	input wire logic i_reset_pin,
	input wire pmh_pkg::pmh_wake_t i_wake_src,
	input wire logic i_ring_used,
	input wire logic i_can_used,
	input wire logic i_ext_supply,
	input wire logic [15:0] o_regulator_control_reg,
	input wire pmh_pkg::pmh_ctrl_t o_ctrl,
	input wire pmh_pkg::pmh_mode_t o_mode,
	input wire logic o_boot_start,
	input wire logic o_reg_bypass,
	input wire logic [10:0] o_core_mv
);
	// ----
	// Checks
	// ----
	logic deep, hib, wake;
	logic [4:0] en;
	assign deep = (o_mode == pmh_pkg::PMH_DEEP_SLEEP);
	assign hib = (o_mode == pmh_pkg::PMH_HIBERNATE);
	assign en = o_regulator_control_reg[12:8];
	assign wake = i_wake_src.reset | (i_wake_src.rtc & en[0]) | (i_wake_src.can & en[1])
		| (i_wake_src.ring_rx_activity_pin & en[3])
		| (i_wake_src.gp & en[4] & ~(i_ring_used & i_can_used));
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);
	a_deep_gated: assert property (deep |-> o_ctrl[6:5] == 2'h0 && o_ctrl.async_block)
		else $error("deep sleep clocks or bus open");
	a_deep_hold: assert property (deep && !i_reset_pin && !i_rtc_async_irq |=> deep)
		else $error("deep sleep left without cause");
	a_deep_rtc: assert property (deep && i_rtc_async_irq && !i_reset_pin |=> o_mode == pmh_pkg::PMH_ACTIVE)
		else $error("rtc wake did not reach active");
	a_deep_reset: assert property (deep && i_reset_pin |=> o_mode == pmh_pkg::PMH_FULL_ON)
		else $error("reset pin did not reach full-on");
	a_hib_entry: assert property ((o_mode == pmh_pkg::PMH_FULL_ON || o_mode == pmh_pkg::PMH_ACTIVE)
		&& i_reg_we && i_reg_wdata[1:0] == 2'h0 && !i_ext_supply
		|=> hib && o_ctrl[6:5] == 2'h0 && o_ctrl.pins_hiz && !o_ctrl.supply_on && o_core_mv == 11'h000)
		else $error("hibernate entry wrong");
	a_hib_wake: assert property (hib && wake |-> ##2 o_mode == pmh_pkg::PMH_BOOT)
		else $error("hibernate wake missed");
	a_boot_seq: assert property (o_mode == pmh_pkg::PMH_BOOT && $past(hib)
		|-> ##100 o_mode == pmh_pkg::PMH_FULL_ON && o_boot_start)
		else $error("boot sequence wrong");
	a_full_pll: assert property (o_mode == pmh_pkg::PMH_FULL_ON |-> o_ctrl[6:3] == 4'hE)
		else $error("full-on clock setting wrong");
	a_active_byp: assert property (o_mode == pmh_pkg::PMH_ACTIVE |-> o_ctrl[6:3] == 4'hF)
		else $error("active clock setting wrong");
	a_ext_refuse: assert property (i_ext_supply && !hib |=> o_reg_bypass && !hib)
		else $error("external supply not honoured");
endmodule
`default_nettype wire

// ==== bench/tb_pmh_seq.sv ====
// Directed testbench for the power-mode sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_pmh_seq;
	logic i_clk = 1'h0, i_rst = 1'h1, i_reg_we = 1'h0, i_sleep_req = 1'h0;
	logic i_deep_sleep_req = 1'h0, i_active_req = 1'h0, i_full_on_req = 1'h0;
	logic i_pll_bypass_cfg = 1'h0, i_wake_evt = 1'h0, i_rtc_async_irq = 1'h0;
	logic i_reset_pin = 1'h0, i_ring_used = 1'h1, i_can_used = 1'h1, i_ext_supply = 1'h0;
	logic [15:0] i_reg_wdata = 16'h0000;
	pmh_pkg::pmh_wake_t i_wake_src = 5'h00;
	logic [15:0] o_regulator_control_reg;
	pmh_pkg::pmh_ctrl_t o_ctrl;
	pmh_pkg::pmh_mode_t o_mode;
	logic o_boot_start, o_reg_enable, o_reg_bypass;
	logic [10:0] o_core_mv;
	int err_total = 0;
	int n_checks = 0;
	always #5 i_clk = ~i_clk;
	pmh_seq i_pmh_seq (.i_clk, .i_rst, .i_reg_we, .i_reg_wdata, .i_sleep_req, .i_deep_sleep_req,
		.i_active_req, .i_full_on_req, .i_pll_bypass_cfg, .i_wake_evt, .i_rtc_async_irq,
		.i_reset_pin, .i_wake_src, .i_ring_used, .i_can_used, .i_ext_supply,
		.o_regulator_control_reg, .o_ctrl, .o_mode, .o_boot_start, .o_reg_enable,
		.o_reg_bypass, .o_core_mv);
	// ----
	// Tasks
	// ----
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic wait_mode(input pmh_pkg::pmh_mode_t m, output int n);
		n = 0;
		while (o_mode !== m) begin
			step(1);
			n++;
			if (n > 300) begin
				err_total++;
				close_out();
			end
		end
	endtask
	task automatic wr(input logic [15:0] d);
		i_reg_we = 1'h1;
		i_reg_wdata = d;
		step(1);
		i_reg_we = 1'h0;
		step(1);
	endtask
	task automatic t_deep(input logic by_pin);
		i_deep_sleep_req = 1'h1;
		step(1);
		i_deep_sleep_req = 1'h0;
		chk(o_ctrl[6:5], 2'h0);
		chk(o_ctrl.async_block, 1'h1);
		{i_wake_evt, i_sleep_req, i_active_req, i_full_on_req} = 4'hF;
		wr(16'h1F30);
		{i_wake_evt, i_sleep_req, i_active_req, i_full_on_req} = 4'h0;
		chk(o_mode, pmh_pkg::PMH_DEEP_SLEEP);
		i_reset_pin = by_pin;
		i_rtc_async_irq = !by_pin;
		step(1);
		{i_reset_pin, i_rtc_async_irq} = 2'h0;
		chk(o_mode, by_pin ? pmh_pkg::PMH_FULL_ON : pmh_pkg::PMH_ACTIVE);
		chk(o_ctrl[6:3], by_pin ? 4'hE : 4'hF);
	endtask
	task automatic t_hib(input int b);
		int n;
		logic [4:0] en;
		logic [3:0] lvl;
		en = (5'h01 << (4 - b)) | 5'h04;
		lvl = 4'(b + 3);
		i_ring_used = (b != 0);
		wr({3'h0, en, lvl, 4'h1});
		chk(o_core_mv, 11'(pmh_pkg::PMH_VOLT_BASE_MV + 50 * lvl));
		chk(o_regulator_control_reg, {3'h0, en, lvl, 4'h1});
		wr({3'h0, en, lvl, 4'h0});
		chk(o_mode, pmh_pkg::PMH_HIBERNATE);
		chk({o_ctrl[6:5], o_ctrl[1:0], o_core_mv}, 15'h1000);
		i_wake_src = 5'h1B & ~(5'h01 << b);
		step(4);
		chk(o_mode, pmh_pkg::PMH_HIBERNATE);
		i_wake_src = 5'h01 << b;
		step(1);
		i_wake_src = 5'h00;
		wait_mode(pmh_pkg::PMH_BOOT, n);
		chk(n, 16'h0001);
		wait_mode(pmh_pkg::PMH_FULL_ON, n);
		chk(n, pmh_pkg::PMH_BOOT_CYCLES);
		chk(o_boot_start, 1'h1);
		step(1);
		chk(o_boot_start, 1'h0);
	endtask
	task automatic t_ext();
		i_ext_supply = 1'h1;
		wr(16'h1FB0);
		chk({o_mode, o_reg_bypass, o_reg_enable}, 5'h02);
		wr(pmh_pkg::PMH_CTL_RESET);
		i_ext_supply = 1'h0;
		step(1);
		chk(o_reg_enable, 1'h1);
	endtask
	initial begin
		step(8);
		i_rst = 1'h0;
		chk(o_regulator_control_reg, pmh_pkg::PMH_CTL_RESET);
		chk(o_ctrl, 7'h71);
		chk(o_core_mv, 16'(pmh_pkg::PMH_VOLT_BASE_MV + 50 * pmh_pkg::PMH_CTL_RESET[7:4]));
		t_deep(1'h0);
		t_deep(1'h1);
		for (int b = 0; b < 5; b++) begin
			t_hib(b);
		end
		t_ext();
		close_out();
	end
endmodule
bind pmh_seq pmh_seq_properties i_pmh_seq_properties (.i_clk, .i_rst, .i_reg_we, .i_reg_wdata,
	.i_rtc_async_irq, .i_reset_pin, .i_wake_src, .i_ring_used, .i_can_used, .i_ext_supply,
	.o_regulator_control_reg, .o_ctrl, .o_mode, .o_boot_start, .o_reg_bypass, .o_core_mv);
`default_nettype wire
